//--- verilog/dasr_top.sv
// dasr_top.sv: serial readout of a 13-bit differential converter, device end of the link.
// assumes: SCLK is the host's serial clock, CS_N the host's chip select; DIFF_IN is the
// digitised differential input (positive minus negative) on CLK, standing in for the
// analog front end; SDO and SDO_OE form the three-state data pin.
//
// How it works
// R01: results are two's complement, sign bit then twelve data bits.
// R02: sign is zero when positive input is larger, one when negative is larger.
// R03: codes clip at +4095 and -4096.
// R04: equal inputs give zero sign and zero data.
// R05: chip select falling starts a frame.
// R06: host must toggle chip select if low at power-up.
// R07: sampling starts at first rising serial clock after chip select falls.
// R08: at falling edge of clock two, output a low null bit.
// R09: next 13 clocks send result MSB first.
// R10: data output changes only on falling serial clock edges.
// R11: further clocks resend the result LSB first.
// R12: after the LSB-first copy, further clocks give zeros.
// R13: host gives 16 clocks per conversion, e.g. two bytes.
// R14: host samples on rising edges, mode 0,0 or 1,1.
// R15: output is high impedance during the first two clocks.
// R16: first byte: two unknown, null, sign, top four; second byte: low eight.
// R17: LSB-first output begins at falling edge of clock 16.
// R18: after sampling, one bit resolves per serial clock.
// R19: host keeps serial clock at least 85 kHz during conversion.
// R20: acquisition lasts 1.5 serial clock cycles.
// R21: chip select high ends the frame and floats the output.
`timescale 1ns/1ps
`include "dasr_regs.svh"
module dasr_top
    import dasr_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        RESET,
    input  wire logic [15:0] DIFF_IN,
    input  wire logic        SCLK,
    input  wire logic        CS_N,
    output logic             SDO,
    output logic             SDO_OE,
    output logic             BUSY
);
    // system-clock side: register the input and quantise continuously
    logic [15:0]  diff_q;
    logic [12:0]  code_sys;

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            diff_q <= 16'h0000;
        end else begin
            diff_q <= DIFF_IN;
        end
    end

    dasr_quant u_quant (
        .clk  (CLK),
        .rst  (RESET),
        .diff (diff_q),
        .code (code_sys)
    );

    // held code is stable between handshakes, so the link side may copy it whole
    logic [12:0]  code_hold;
    logic         req_tog;
    logic         req_sync;
    logic         ack_tog;

    dasr_sync u_req_sync (
        .clk (CLK),
        .rst (RESET),
        .d   (req_tog),
        .q   (req_sync)
    );

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            ack_tog   <= 1'b0;
            code_hold <= 13'h0000;
        end else if (req_sync != ack_tog) begin
            ack_tog   <= req_sync;
            code_hold <= code_sys;
        end
    end

    // frame is held in reset while chip select is high; release is asynchronous
    // to SCLK, but no SCLK edge arrives until the host has settled CS_N low
    logic         frame_rst;
    assign frame_rst = CS_N | RESET; // R05 R21

    logic [5:0]            rise_cnt;
    logic [5:0]            fall_cnt;
    dasr_result_t          result;
    dasr_pin_t             pin;

    // rising edges: acquisition opens at the first one and requests a fresh code
    always_ff @(posedge SCLK or posedge frame_rst) begin
        if (frame_rst) begin
            rise_cnt <= 6'h00;
        end else if (rise_cnt != `DASR_CNT_SAT) begin
            rise_cnt <= rise_cnt + 6'h01;
        end
    end

    // request toggles at the first rising edge; ack arrives within a few CLK
    // cycles, far sooner than the 1.5 clocks of acquisition at any legal SCLK
    logic req_src;
    always_ff @(posedge SCLK or posedge RESET) begin
        if (RESET) begin
            req_src <= 1'b0;
        end else if (!CS_N && rise_cnt == 6'h00) begin
            req_src <= ~req_src; // R07 R20
        end
    end
    assign req_tog = req_src;

    // falling edges drive the data pin; with the clock idling high the first
    // fall comes before any rise and is not a clock of the frame
    always_ff @(negedge SCLK or posedge frame_rst) begin
        if (frame_rst) begin
            fall_cnt <= 6'h00;
        end else if (rise_cnt != 6'h00 && fall_cnt != `DASR_CNT_SAT) begin // R14
            fall_cnt <= fall_cnt + 6'h01;
        end
    end

    // edge number sticks at its ceiling so a very long frame keeps sending zeros
    logic [5:0] edge_no;
    logic [5:0] msb_idx;
    logic [5:0] lsb_idx;
    assign edge_no = (fall_cnt == `DASR_CNT_SAT) ? `DASR_CNT_SAT : fall_cnt + 6'h01; // R12
    assign msb_idx = `DASR_MSB_LAST_EDGE - edge_no;
    assign lsb_idx = edge_no - `DASR_MSB_LAST_EDGE;

    // code is captured at the null-bit edge, when sampling ends
    always_ff @(negedge SCLK or posedge frame_rst) begin
        if (frame_rst) begin
            result <= '0;
        end else if (edge_no == `DASR_NULL_EDGE) begin
            result.valid <= 1'b1;
            result.code  <= code_hold; // R08 R18
        end
    end

    function automatic dasr_phase_t phase_of(input logic [5:0] edge_no);
        if (edge_no < `DASR_NULL_EDGE) begin
            phase_of = DASR_IDLE;
        end else if (edge_no == `DASR_NULL_EDGE) begin
            phase_of = DASR_SAMP;
        end else if (edge_no <= `DASR_MSB_LAST_EDGE) begin
            phase_of = DASR_MSB;
        end else if (edge_no <= `DASR_LSB_LAST_EDGE) begin
            phase_of = DASR_LSB;
        end else begin
            phase_of = DASR_IDLE;
        end
    endfunction

    function automatic logic code_hold_bit(input logic [5:0] idx);
        code_hold_bit = result.code[idx[3:0]];
    endfunction

    always_ff @(negedge SCLK or posedge frame_rst) begin
        if (frame_rst) begin
            pin <= '0;
        end else begin
            unique case (phase_of(edge_no))
                DASR_IDLE: begin
                    pin.sdo    <= 1'b0; // R12
                    pin.sdo_oe <= (edge_no >= `DASR_NULL_EDGE); // R15
                end
                DASR_SAMP: begin
                    pin.sdo    <= 1'b0; // R08
                    pin.sdo_oe <= 1'b1;
                end
                DASR_MSB: begin
                    pin.sdo    <= code_hold_bit(msb_idx); // R09 R10 R16
                    pin.sdo_oe <= 1'b1;
                end
                DASR_LSB: begin
                    pin.sdo    <= code_hold_bit(lsb_idx); // R11 R17
                    pin.sdo_oe <= 1'b1;
                end
            endcase
        end
    end

    assign SDO    = pin.sdo;
    assign SDO_OE = pin.sdo_oe;

    // busy reports an open frame on CLK, through the synchroniser
    logic cs_low_sync;
    dasr_sync u_cs_sync (
        .clk (CLK),
        .rst (RESET),
        .d   (~CS_N),
        .q   (cs_low_sync)
    );

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            BUSY <= 1'b0;
        end else begin
            BUSY <= cs_low_sync;
        end
    end
endmodule

//--- verilog/dasr_regs.svh
// dasr_regs.svh: frame positions and code limits of the differential converter readout.
// assumes: included by the package and by dasr_top and dasr_quant, no other dependency.
`ifndef DASR_REGS_SVH
`define DASR_REGS_SVH

`define DASR_CODE_W        13
`define DASR_CNT_W         6
`define DASR_CODE_MAX      13'h0FFF
`define DASR_CODE_MIN      13'h1000
`define DASR_NULL_EDGE     6'h02
`define DASR_MSB_LAST_EDGE 6'h0F
`define DASR_LSB_LAST_EDGE 6'h1B
`define DASR_CNT_SAT       6'h3F

`endif

//--- verilog/dasr_pkg.sv
// dasr_pkg.sv: types shared by the readout modules.
// assumes: dasr_regs.svh is on the include path.
`include "dasr_regs.svh"
package dasr_pkg;
    typedef enum logic [1:0] {
        DASR_IDLE = 2'b00,
        DASR_SAMP = 2'b01,
        DASR_MSB  = 2'b10,
        DASR_LSB  = 2'b11
    } dasr_phase_t;

    typedef struct packed {
        logic                     valid;
        logic [`DASR_CODE_W-1:0] code;
    } dasr_result_t;

    typedef struct packed {
        logic sdo;
        logic sdo_oe;
    } dasr_pin_t;
endpackage

//--- verilog/dasr_sync.sv
// dasr_sync.sv: two-flop level synchroniser.
// assumes: input is asynchronous to clk; stage one is read only by stage two.
`timescale 1ns/1ps
module dasr_sync (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic d,
    output logic      q
);
    logic meta;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta <= 1'b0;
            q    <= 1'b0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule

//--- verilog/dasr_quant.sv
// dasr_quant.sv: turns a signed difference into a saturated 13-bit two's complement code.
// assumes: diff is a registered value on the system clock.
`timescale 1ns/1ps
`include "dasr_regs.svh"
module dasr_quant
    import dasr_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [15:0] diff,
    output logic [12:0]      code
);
    function automatic logic [12:0] sat13(input logic [15:0] v);
        if (!v[15] && v[14:12] != 3'h0) begin
            sat13 = `DASR_CODE_MAX; // R03
        end else if (v[15] && v[14:12] != 3'h7) begin
            sat13 = `DASR_CODE_MIN; // R03
        end else begin
            sat13 = v[12:0]; // R01 R02 R04
        end
    endfunction

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            code <= 13'h0000;
        end else begin
            code <= sat13(diff);
        end
    end
endmodule

//--- dv/dasr_top_chk.sv
// dasr_top_chk.sv: port assertions for the converter readout.
// assumes: bound to dasr_top; SCLK moves to its idle level before CS_N falls and again before CS_N rises.
`timescale 1ns/1ps
module dasr_top_chk (
    input wire logic        CLK,
    input wire logic        RESET,
    input wire logic [15:0] DIFF_IN,
    input wire logic        SCLK,
    input wire logic        CS_N,
    input wire logic        SDO,
    input wire logic        SDO_OE,
    input wire logic        BUSY
);
    logic [5:0]  rises;
    logic [12:0] code;
    // value sampled at rise k is k-1
    always_ff @(posedge SCLK or posedge CS_N) begin
        if (CS_N) begin
            rises <= 6'h00;
        end else if (rises != 6'h3F) begin
            rises <= rises + 6'h01;
        end
    end
    // result as sent msb first, replayed against the lsb-first copy
    always_ff @(posedge SCLK) begin
        if (rises >= 6'h03 && rises <= 6'h0F) begin
            code <= {code[11:0], SDO};
        end
    end
    hiz_first_a: assert property (@(posedge SCLK) disable iff (CS_N || RESET)
        rises < 6'h02 |-> !SDO_OE) else $error("pin driven early");
    null_bit_a: assert property (@(posedge SCLK) disable iff (CS_N || RESET)
        rises == 6'h02 |-> SDO_OE && !SDO) else $error("no null bit");
    result_drive_a: assert property (@(posedge SCLK) disable iff (CS_N || RESET)
        rises >= 6'h03 && rises <= 6'h1B |-> SDO_OE) else $error("pin floats in result");
    lsb_copy_a: assert property (@(posedge SCLK) disable iff (CS_N || RESET)
        rises >= 6'h10 && rises <= 6'h1B |-> SDO == code[rises - 6'h0F])
        else $error("lsb copy wrong");
    zero_tail_a: assert property (@(posedge SCLK) disable iff (CS_N || RESET)
        rises >= 6'h1C |-> SDO_OE && !SDO) else $error("tail not zero");
    float_off_a: assert property (@(posedge CLK) disable iff (RESET)
        CS_N |-> !SDO_OE) else $error("pin driven while deselected");
    fall_edge_a: assert property (@(posedge CLK) disable iff (RESET)
        SDO_OE && $past(SDO_OE) && $changed(SDO) |-> !SCLK) else $error("data moved on rise");
    busy_on_a: assert property (@(posedge CLK) disable iff (RESET)
        $fell(CS_N) |-> ##[1:4] BUSY) else $error("busy late");
    busy_off_a: assert property (@(posedge CLK) disable iff (RESET)
        $rose(CS_N) |-> ##[1:4] !BUSY) else $error("busy stuck");
endmodule
bind dasr_top dasr_top_chk dasr_top_chk_i (.CLK(CLK), .RESET(RESET), .DIFF_IN(DIFF_IN),
    .SCLK(SCLK), .CS_N(CS_N), .SDO(SDO), .SDO_OE(SDO_OE), .BUSY(BUSY));

//--- dv/dasr_host.sv
// dasr_host.sv: host spi port model, framing and capture on rising edges.
// assumes: tasks are entered on a falling system clock edge.
`timescale 1ns/1ps
module dasr_host (
    output logic      SCLK,
    output logic      CS_N,
    input  wire logic SDO,
    input  wire logic SDO_OE
);
    // select found low at power-up, so it is raised before any frame
    initial begin
        SCLK = 1'b0;
        CS_N = 1'b0;
        #10 CS_N = 1'b1;
    end
    // clock settles to its idle level while deselected; odd delay keeps SCLK off CLK edges
    task automatic frame(input logic idle_hi, input int n,
                         output logic [127:0] oe, output logic [127:0] sd);
        oe = '0;
        sd = '0;
        SCLK = idle_hi;
        #10 CS_N = 1'b0;
        #21;
        for (int k = 1; k <= n; k++) begin
            SCLK = 1'b0;
            #15;
            SCLK = 1'b1;
            oe[k] = SDO_OE;
            sd[k] = SDO;
            #15;
        end
        SCLK = idle_hi;
        #20 CS_N = 1'b1;
        #30;
    endtask
endmodule

//--- dv/dasr_top_tb_top.sv
// dasr_top_tb_top.sv: readout bench, codes across both clock modes.
// assumes: dasr_host provides the serial link.
`timescale 1ns/1ps
module dasr_top_tb_top;
    import dasr_pkg::*;
    logic        CLK = 1'b0;
    logic        RESET = 1'b1;
    logic [15:0] DIFF_IN = 16'h0000;
    logic        SCLK, CS_N, SDO, SDO_OE, BUSY;
    int          num_errors = 0;
    int          samples_checked = 0;
    logic [15:0] vals [10] = '{16'h0000, 16'h0001, 16'hFFFF, 16'h0FFF, 16'h0FFE,
                               16'h1388, 16'hF000, 16'hE890, 16'h0002, 16'hF001};
    always #2.5 CLK = ~CLK;
    dasr_top dasr_top_i (.CLK(CLK), .RESET(RESET), .DIFF_IN(DIFF_IN), .SCLK(SCLK),
        .CS_N(CS_N), .SDO(SDO), .SDO_OE(SDO_OE), .BUSY(BUSY));
    dasr_host dasr_host_i (.SCLK(SCLK), .CS_N(CS_N), .SDO(SDO), .SDO_OE(SDO_OE));
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %0t seen %h wanted %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        if (num_errors == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    function automatic logic [12:0] sat(input logic signed [15:0] d);
        if (d > 16'sh0FFF) return 13'h0FFF;
        if (d < -16'sh1000) return 13'h1000;
        return d[12:0];
    endfunction
    task automatic full_frame(input logic [15:0] d, input logic idle_hi);
        logic [127:0] oe, sd;
        logic [12:0]  exp, msb;
        exp = sat(d);
        DIFF_IN = d;
        repeat (10) @(negedge CLK);
        dasr_host_i.frame(idle_hi, 32, oe, sd);
        msb = {<<{sd[16:4]}};
        chk(oe[2:1], 32'h0);
        chk({oe[3], sd[3]}, 32'h2);
        chk(msb, exp);
        chk(oe[32:3], 32'h3FFFFFFF);
        chk(sd[28:16], exp);
        chk(sd[32:29], 32'h0);
        chk(SDO_OE, 32'h0);
    endtask
    task automatic two_bytes(input logic [15:0] d);
        logic [127:0] oe, sd;
        logic [12:0]  exp;
        logic [7:0]   b1, b2;
        exp = sat(d);
        DIFF_IN = d;
        repeat (10) @(negedge CLK);
        dasr_host_i.frame(1'b0, 16, oe, sd);
        b1 = {<<{sd[8:1]}};
        b2 = {<<{sd[16:9]}};
        chk({oe[2:1], b1[5:0], b2}, {2'b00, 1'b0, exp});
    endtask
    // runs past the frame counter's ceiling: the tail must stay driven and zero
    task automatic long_tail(input logic [15:0] d);
        logic [127:0] oe, sd;
        DIFF_IN = d;
        repeat (10) @(negedge CLK);
        dasr_host_i.frame(1'b1, 70, oe, sd);
        chk(oe[70:7], {64{1'b1}});
        chk(sd[70:29], 64'h0);
    endtask
    // reset between frames must float the pin and clear busy, then frames work again
    task automatic mid_reset();
        @(negedge CLK);
        RESET = 1'b1;
        repeat (4) @(negedge CLK);
        chk({BUSY, SDO_OE, SDO}, 64'h0);
        RESET = 1'b0;
        repeat (4) @(negedge CLK);
        full_frame(16'h0003, 1'b1);
    endtask
    initial begin
        #200000;
        num_errors++;
        print_verdict();
    end
    initial begin
        repeat (8) @(negedge CLK);
        RESET = 1'b0;
        repeat (4) @(negedge CLK);
        for (int i = 0; i < 10; i++) full_frame(vals[i], i[0]);
        two_bytes(16'h0A5C);
        two_bytes(16'hF5A3);
        long_tail(16'h8000);
        mid_reset();
        print_verdict();
    end
endmodule
